/* File: core/ars_regs.sv */
module ars_regs
  import ars_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = ars_pkg::DEV_ADDR_DEF
) (
  input  wire logic                    I_MCLK,
  input  wire logic                    I_RSTN,
  input  wire logic                    I_SCL,
  input  wire logic                    I_SDA,
  output logic                         O_SDA_OUT,
  output logic                         O_SDA_OEN,
  input  wire ars_pkg::ars_alert_cfg_t I_ALERT_CFG,
  input  wire ars_pkg::ars_conv_t      I_CONV,
  output logic                         O_CONV_START,
  output ars_pkg::ars_ext_wr_t         O_EXT_WR,
  output logic [2:0]                   O_EXT_SEL,
  input  wire logic [15:0]             I_EXT_RDATA,
  output logic [1:0]                   O_ALERT_FLAGS
);
  import ars_pkg::*;

  // ------------------------------------------------------------
  // Bus pin sampling
  // ------------------------------------------------------------
  logic [1:0] line_f;
  logic       scl_q;
  logic       sda_q;

  ars_sync #(.WIDTH(2)) u_sync (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RSTN),
    .i_d     ({I_SCL, I_SDA}),
    .o_q     (line_f)
  );

  wire scl_f     = line_f[1];
  wire sda_f     = line_f[0];
  wire scl_rise  = scl_f & ~scl_q;
  wire scl_fall  = ~scl_f & scl_q;
  wire start_det = scl_f & scl_q & sda_q & ~sda_f;
  wire stop_det  = scl_f & scl_q & ~sda_q & sda_f;

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  ars_state_t  state;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx_sh;
  logic [7:0]  tx_sh;
  logic        rd_mode;
  logic        first_byte;
  logic        byte_idx;
  logic [7:0]  ptr;
  logic [7:0]  hi_byte;
  logic        sda_low;
  logic [15:0] rd_word;
  logic [7:0]  sample;
  logic [1:0]  flags;

  ars_state_t  next_state;
  logic [3:0]  next_cnt;
  logic [7:0]  next_rx;
  logic [7:0]  next_tx;
  logic        next_rd;
  logic        next_first;
  logic        next_idx;
  logic [7:0]  next_ptr;
  logic [7:0]  next_hi;
  logic        next_low;
  logic [15:0] next_word;
  logic        conv_go;
  logic        ext_go;
  logic [15:0] ext_data;
  logic [1:0]  flag_w1c;
  logic [1:0]  next_flags;

  // Byte-wide registers move one byte per access, the others two
  function automatic logic is_byte_reg(input logic [2:0] sel);
    return (sel == SEL_FLAGS) || (sel == SEL_CONFIG);
  endfunction

  // ------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------
  // low select bits
  wire [2:0]  sel       = ptr[2:0];
  wire        alert_bit = I_ALERT_CFG.flag_en & (|flags);
  logic [15:0] result_word;
  logic [7:0]  flags_word;

  always_comb begin
    result_word                  = RESULT_RESET;
    result_word[RES_MSB:RES_LSB] = sample;
    result_word[RES_ALERT]       = alert_bit;
  end

  always_comb begin
    flags_word             = FLAGS_RESET;
    flags_word[FLAG_OVER]  = flags[FLAG_OVER];
    flags_word[FLAG_UNDER] = flags[FLAG_UNDER];
  end

  wire [15:0] sel_word = (sel == SEL_RESULT) ? result_word :
                         (sel == SEL_FLAGS)  ? {8'h00, flags_word} : I_EXT_RDATA;
  wire [7:0]  rd_byte  = (is_byte_reg(sel) || byte_idx) ? rd_word[7:0] : rd_word[15:8];
  wire        wr_done  = (state == ST_WRITE) && scl_fall && (bit_cnt == BIT_LAST);

  // ------------------------------------------------------------
  // Transfer sequencing
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt   = bit_cnt;
    next_rx    = rx_sh;
    next_tx    = tx_sh;
    next_rd    = rd_mode;
    next_first = first_byte;
    next_idx   = byte_idx;
    next_ptr   = ptr;
    next_hi    = hi_byte;
    next_low   = sda_low;
    next_word  = rd_word;
    conv_go    = 1'b0;
    ext_go     = 1'b0;
    ext_data   = {hi_byte, rx_sh};
    flag_w1c   = 2'h0;
    if (scl_rise && (state == ST_ADDR || state == ST_WRITE || state == ST_READ)) begin
      next_rx  = {rx_sh[6:0], sda_f};
      next_cnt = bit_cnt + BIT_ONE;
    end
    case (state)
      ST_IDLE: begin
        next_low = 1'b0;
      end
      ST_ADDR: begin
        if (scl_fall && bit_cnt == BIT_LAST) begin
          if (rx_sh[7:1] == DEV_ADDR) begin
            next_state = ST_ADDR_ACK;
            next_low   = 1'b1;
            next_rd    = rx_sh[0];
            next_first = 1'b1;
            next_idx   = 1'b0;
            next_word  = sel_word;
            conv_go    = rx_sh[0] && (sel == SEL_RESULT) && !I_ALERT_CFG.auto_mode;
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_ADDR_ACK: begin
        if (scl_fall) begin
          next_cnt = BIT_ZERO;
          if (rd_mode) begin
            next_state = ST_READ;
            next_low   = ~rd_byte[7];
            next_tx    = {rd_byte[6:0], 1'b0};
          end else begin
            next_state = ST_WRITE;
            next_low   = 1'b0;
          end
        end
      end
      ST_WRITE: begin
        if (wr_done) begin
          next_state = ST_WR_ACK;
          next_low   = 1'b1;
          if (first_byte) begin
            next_ptr   = rx_sh;
            next_first = 1'b0;
          end else if (is_byte_reg(sel)) begin
            flag_w1c = (sel == SEL_FLAGS) ? rx_sh[1:0] : 2'h0;
            ext_go   = (sel == SEL_CONFIG);
            ext_data = {8'h00, rx_sh};
          end else if (!byte_idx) begin
            next_hi  = rx_sh;
            next_idx = 1'b1;
          end else begin
            next_idx = 1'b0;
            ext_go   = (sel != SEL_RESULT);
          end
        end
      end
      ST_WR_ACK: begin
        if (scl_fall) begin
          next_state = ST_WRITE;
          next_low   = 1'b0;
          next_cnt   = BIT_ZERO;
        end
      end
      ST_READ: begin
        if (scl_fall) begin
          if (bit_cnt == BIT_LAST) begin
            next_state = ST_RD_ACK;
            next_low   = 1'b0;
            next_idx   = ~byte_idx;
          end else begin
            next_low = ~tx_sh[7];
            next_tx  = {tx_sh[6:0], 1'b0};
          end
        end
      end
      ST_RD_ACK: begin
        if (scl_rise && sda_f) begin
          next_state = ST_IDLE;
        end else if (scl_fall) begin
          next_state = ST_READ;
          next_cnt   = BIT_ZERO;
          next_low   = ~rd_byte[7];
          next_tx    = {rd_byte[6:0], 1'b0};
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_low   = 1'b0;
      end
    endcase
    // Start and stop override any phase of a transfer
    if (start_det) begin
      next_state = ST_ADDR;
      next_cnt   = BIT_ZERO;
      next_low   = 1'b0;
    end else if (stop_det) begin
      next_state = ST_IDLE;
      next_low   = 1'b0;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state      <= ST_IDLE;
      bit_cnt    <= BIT_ZERO;
      rx_sh      <= 8'h00;
      tx_sh      <= 8'h00;
      rd_mode    <= 1'b0;
      first_byte <= 1'b0;
      byte_idx   <= 1'b0;
      hi_byte    <= 8'h00;
      sda_low    <= 1'b0;
      rd_word    <= RESULT_RESET;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_cnt;
      rx_sh      <= next_rx;
      tx_sh      <= next_tx;
      rd_mode    <= next_rd;
      first_byte <= next_first;
      byte_idx   <= next_idx;
      hi_byte    <= next_hi;
      sda_low    <= next_low;
      rd_word    <= next_word;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ptr <= PTR_RESET;
    end else begin
      ptr <= next_ptr;
    end
  end

  // ------------------------------------------------------------
  // Sample store and limit flags
  // ------------------------------------------------------------
  wire [8:0] smp9    = {1'b0, I_CONV.data};
  wire [8:0] high9   = {1'b0, I_ALERT_CFG.high};
  wire [8:0] low9    = {1'b0, I_ALERT_CFG.low};
  wire [8:0] margin9 = {1'b0, I_ALERT_CFG.threshold_margin};
  wire set_over   = I_CONV.done && (smp9 > high9);
  wire set_under  = I_CONV.done && (smp9 < low9);
  // over release; sum form avoids underflow when margin exceeds limit
  wire self_over  = I_CONV.done && !I_ALERT_CFG.hold && ((smp9 + margin9) < high9);
  wire self_under = I_CONV.done && !I_ALERT_CFG.hold && (smp9 > (low9 + margin9));

  // write one clears, a new violation wins
  always_comb begin
    next_flags[FLAG_OVER]  = set_over  |
      (flags[FLAG_OVER]  & ~self_over  & ~flag_w1c[FLAG_OVER]);
    next_flags[FLAG_UNDER] = set_under |
      (flags[FLAG_UNDER] & ~self_under & ~flag_w1c[FLAG_UNDER]);
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      flags  <= FLAGS_RESET[1:0];
      sample <= SAMPLE_RESET;
    end else begin
      flags <= next_flags;
      if (I_CONV.done) begin
        sample <= I_CONV.data;
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_CONV_START <= 1'b0;
      O_EXT_WR     <= '0;
    end else begin
      O_CONV_START <= conv_go;
      O_EXT_WR     <= '{stb: ext_go, sel: sel, data: ext_data};
    end
  end

  // Open drain: the line is only ever pulled low
  assign O_SDA_OUT     = 1'b0;
  assign O_SDA_OEN     = ~sda_low;
  assign O_EXT_SEL     = sel;
  assign O_ALERT_FLAGS = flags;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);

  wire first_wr = wr_done && first_byte;
  wire rd_ack   = (state == ST_ADDR) && (next_state == ST_ADDR_ACK) && rx_sh[0];

  a_ptr_first_load: assert property (first_wr |=> ptr == $past(rx_sh))
    else $error("pointer not loaded from first write byte");
  a_ptr_hold: assert property (!first_wr |=> $stable(ptr))
    else $error("pointer changed without a first write byte");
  a_conv_on_read: assert property (
    rd_ack && sel == SEL_RESULT && !I_ALERT_CFG.auto_mode |=> O_CONV_START && !O_SDA_OEN)
    else $error("result read did not start a conversion at acknowledge");
  a_conv_cause: assert property (O_CONV_START |-> $past(rd_ack) && !O_SDA_OEN)
    else $error("conversion start without read acknowledge");
  a_result_ro: assert property (O_EXT_WR.stb |-> O_EXT_WR.sel != SEL_RESULT)
    else $error("write reached the result register");
  a_sample_cause: assert property (!$stable(sample) |-> $past(I_CONV.done))
    else $error("result changed without a conversion");
  a_over_set: assert property (set_over |=> flags[FLAG_OVER])
    else $error("over flag not set above upper limit");
  a_under_set: assert property (set_under |=> flags[FLAG_UNDER])
    else $error("under flag not set below lower limit");
  a_hold_keep: assert property (
    I_ALERT_CFG.hold && flags[FLAG_OVER] && !flag_w1c[FLAG_OVER] |=> flags[FLAG_OVER])
    else $error("held over flag cleared by itself");
  a_over_release: assert property (self_over && !set_over |=> !flags[FLAG_OVER])
    else $error("over flag did not self-clear");
  a_under_w1c: assert property (flag_w1c[FLAG_UNDER] && !set_under |=> !flags[FLAG_UNDER])
    else $error("under flag not cleared by write one");
  a_alert_bit: assert property (
    rd_ack && sel == SEL_RESULT |=> rd_word[RES_ALERT] == $past(alert_bit))
    else $error("alert bit of result snapshot wrong");

  c_result_read: cover property (rd_ack && sel == SEL_RESULT ##1 O_CONV_START);
  c_ext_write:   cover property (O_EXT_WR.stb);
  // A read sits between two conversions, so the release comes hundreds of cycles later
  c_over_flag:   cover property (set_over ##[1:1000] self_over);
  c_flag_w1c:    cover property (flags[FLAG_UNDER] && flag_w1c[FLAG_UNDER]);
endmodule

/* File: core/ars_pkg.sv */
package ars_pkg;
  // ------------------------------------------------------------
  // Register select codes
  // ------------------------------------------------------------
  localparam logic [2:0]  SEL_RESULT   = 3'h0;
  localparam logic [2:0]  SEL_FLAGS    = 3'h1;
  localparam logic [2:0]  SEL_CONFIG   = 3'h2;
  localparam logic [2:0]  SEL_LOW      = 3'h3;
  localparam logic [2:0]  SEL_HIGH     = 3'h4;
  localparam logic [2:0]  SEL_MARGIN   = 3'h5;
  localparam logic [2:0]  SEL_LOWEST   = 3'h6;
  localparam logic [2:0]  SEL_HIGHEST  = 3'h7;

  // ------------------------------------------------------------
  // Reset values and field layout
  // ------------------------------------------------------------
  localparam logic [7:0]  PTR_RESET     = 8'h00;
  localparam logic [15:0] RESULT_RESET  = 16'h0000;
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic [7:0]  SAMPLE_RESET  = 8'h00;
  localparam int unsigned RES_MSB       = 11;
  localparam int unsigned RES_LSB       = 4;
  localparam int unsigned RES_ALERT     = 15;
  localparam int unsigned FLAG_OVER     = 1;
  localparam int unsigned FLAG_UNDER    = 0;
  localparam logic [3:0]  BIT_LAST      = 4'h8;
  localparam logic [3:0]  BIT_ZERO      = 4'h0;
  localparam logic [3:0]  BIT_ONE       = 4'h1;
  // Bus address value is arbitrary
  localparam logic [6:0]  DEV_ADDR_DEF  = 7'h2a;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WRITE    = 3'b011,
    ST_WR_ACK   = 3'b100,
    ST_READ     = 3'b101,
    ST_RD_ACK   = 3'b110
  } ars_state_t;

  typedef struct packed {
    logic       hold;
    logic       flag_en;
    logic       auto_mode;
    logic [7:0] high;
    logic [7:0] low;
    logic [7:0] threshold_margin;
  } ars_alert_cfg_t;

  typedef struct packed {
    logic       done;
    logic [7:0] data;
  } ars_conv_t;

  typedef struct packed {
    logic        stb;
    logic [2:0]  sel;
    logic [15:0] data;
  } ars_ext_wr_t;
endpackage

/* File: core/ars_sync.sv */
module ars_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // ------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  // ------------------------------------------------------------
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        s1[g]  <= 1'b1;
        s2[g]  <= 1'b1;
        s3[g]  <= 1'b1;
        o_q[g] <= 1'b1;
      end else begin
        s1[g] <= i_d[g];
        s2[g] <= s1[g];
        s3[g] <= s2[g];
        if (s2[g] == s3[g]) begin
          o_q[g] <= s3[g];
        end
      end
    end
  end
endmodule

/* File: sim/ars_i2c_host.sv */
module ars_i2c_host
  import ars_pkg::*;
#(
  parameter logic [6:0] ADDR = DEV_ADDR_DEF
) (
  input  wire logic i_sda_out,
  input  wire logic i_sda_oen_n,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------
  // Line model
  // ----------------------------------------------------------
  localparam realtime TQ = 31.25;
  logic pull_low = 1'b0;
  initial o_scl = 1'b1;
  // Pull-up: a released line reads high, never the last driven value
  assign o_sda = (pull_low || (!i_sda_oen_n && !i_sda_out)) ? 1'b0 : 1'b1;

  // ----------------------------------------------------------
  // Bit and byte level
  // ----------------------------------------------------------
  // Also serves as repeated start; clock stands high between frames
  task automatic start_cond();
    #TQ pull_low = 1'b0;
    #TQ o_scl = 1'b1;
    #TQ pull_low = 1'b1;
    #TQ o_scl = 1'b0;
  endtask

  task automatic stop_cond();
    #TQ pull_low = 1'b1;
    #TQ o_scl = 1'b1;
    #TQ pull_low = 1'b0;
    #TQ;
  endtask

  // Data changes mid low phase, sampled mid high phase
  task automatic clock_bit(input logic b, output logic s);
    #TQ pull_low = !b;
    #TQ o_scl = 1'b1;
    #TQ s = o_sda;
    #TQ o_scl = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(b[i], s);
    end
    clock_bit(1'b1, s);
    ack = !s;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      b[i] = s;
    end
    clock_bit(last, s);
  endtask

  // ----------------------------------------------------------
  // Transactions
  // ----------------------------------------------------------
  // pointer byte first, its upper five bits always zero
  task automatic write_reg(input logic [2:0] ptr, input int nbytes, input logic [15:0] v,
                           output logic ok);
    logic a0, a1, a2, a3;
    a2 = 1'b1;
    a3 = 1'b1;
    start_cond();
    send_byte({ADDR, 1'b0}, a0);
    send_byte({5'h00, ptr}, a1);
    if (nbytes == 2) begin
      send_byte(v[15:8], a2);
    end
    if (nbytes >= 1) begin
      send_byte(v[7:0], a3);
    end
    stop_cond();
    ok = a0 & a1 & a2 & a3;
  endtask

  // Last byte is answered with a not-acknowledge to end the read
  task automatic read_reg(input logic [6:0] adr, input int nbytes, output logic [15:0] w,
                          output logic ok);
    w = 'x;
    start_cond();
    send_byte({adr, 1'b1}, ok);
    if (ok) begin
      w[15:8] = 8'h00;
      if (nbytes == 2) begin
        recv_byte(1'b0, w[15:8]);
      end
      recv_byte(1'b1, w[7:0]);
    end
    stop_cond();
  endtask
endmodule

/* File: sim/ars_regs_tb.sv */
module ars_regs_tb
  import ars_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        hold;
    logic        en;
    logic [7:0]  smp;
    logic [1:0]  flg;
    logic [15:0] res;
  } ars_row_t;

  // Limits are low 40, high c0, margin 10; rows run in order
  localparam ars_row_t ROWS [10] = '{
    '{1'b0, 1'b1, 8'h80, 2'b00, 16'h0800},
    '{1'b0, 1'b1, 8'hc1, 2'b10, 16'h8c10},
    '{1'b0, 1'b1, 8'hb0, 2'b10, 16'h8b00},
    '{1'b0, 1'b1, 8'haf, 2'b00, 16'h0af0},
    '{1'b0, 1'b0, 8'h3f, 2'b01, 16'h03f0},
    '{1'b0, 1'b1, 8'h50, 2'b01, 16'h8500},
    '{1'b0, 1'b1, 8'h51, 2'b00, 16'h0510},
    '{1'b1, 1'b1, 8'h00, 2'b01, 16'h8000},
    '{1'b1, 1'b1, 8'h80, 2'b01, 16'h8800},
    '{1'b1, 1'b1, 8'hff, 2'b11, 16'h8ff0}
  };

  logic           mclk = 1'b0;
  logic           rstn = 1'b0;
  logic           scl, sda, sda_out, sda_oen_n, conv_start, ok;
  logic [2:0]     ext_sel;
  logic [1:0]     flags;
  logic [15:0]    ext_rdata, w, v;
  logic [15:0]    ext_reg [8];
  ars_alert_cfg_t cfg = '{1'b0, 1'b1, 1'b0, 8'hc0, 8'h40, 8'h10};
  ars_conv_t      conv = '0;
  ars_ext_wr_t    ext_wr;
  int             err_total = 0;
  int             compares = 0;
  int             starts = 0;
  int             writes = 0;
  int             n;

  always #5 mclk = ~mclk;

  ars_regs i_dut (
    .I_MCLK        (mclk),
    .I_RSTN        (rstn),
    .I_SCL         (scl),
    .I_SDA         (sda),
    .O_SDA_OUT     (sda_out),
    .O_SDA_OEN     (sda_oen_n),
    .I_ALERT_CFG   (cfg),
    .I_CONV        (conv),
    .O_CONV_START  (conv_start),
    .O_EXT_WR      (ext_wr),
    .O_EXT_SEL     (ext_sel),
    .I_EXT_RDATA   (ext_rdata),
    .O_ALERT_FLAGS (flags)
  );

  ars_i2c_host i_host (
    .i_sda_out   (sda_out),
    .i_sda_oen_n (sda_oen_n),
    .o_scl       (scl),
    .o_sda       (sda)
  );

  // ----------------------------------------------------------
  // Outside registers and monitors
  // ----------------------------------------------------------
  assign ext_rdata = ext_reg[ext_sel];

  always @(posedge mclk) begin
    if (ext_wr.stb === 1'b1) begin
      ext_reg[ext_wr.sel] <= ext_wr.data;
      writes++;
    end
    if (conv_start === 1'b1) begin
      starts++;
      check({15'h0, sda_oen_n}, 16'h0000, "start at ack");
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic done_test(input string name);
    $display("Test %s done at %0t", name, $time);
  endtask

  task automatic convert(input logic [7:0] s);
    @(posedge mclk);
    conv <= '{1'b1, s};
    @(posedge mclk);
    conv.done <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask

  task automatic rd(input int nb, input logic [15:0] exp, input string what);
    // Off-edge start keeps every bus event clear of the sampling edge
    @(posedge mclk);
    #1;
    i_host.read_reg(DEV_ADDR_DEF, nb, w, ok);
    check(w, exp, what);
  endtask

  task automatic wr(input logic [2:0] p, input int nb, input logic [15:0] val);
    @(posedge mclk);
    #1;
    i_host.write_reg(p, nb, val, ok);
    check({15'h0, ok}, 16'h0001, "write acknowledged");
  endtask

  task automatic results();
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A hung bus sequence ends the run as a mismatch
  initial begin
    #1000000;
    err_total++;
    $display("Error %0t: run did not finish", $time);
    results();
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    check({13'h0, ext_sel}, 16'h0000, "pointer in reset");
    check({sda_oen_n, flags, sda_out, 12'h0}, 16'h8000, "outputs in reset");
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(2, 16'h0000, "result after reset");
    done_test("reset");
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      cfg.hold <= ROWS[i].hold;
      cfg.flag_en <= ROWS[i].en;
      convert(ROWS[i].smp);
      check({14'h0, flags}, {14'h0, ROWS[i].flg}, "flags");
      n = starts;
      rd(2, ROWS[i].res, "result word");
      check(16'(starts - n), 16'h0001, "read starts conversion");
    end
    done_test("table");
    wr(3'h1, 0, 16'h0000);
    check({13'h0, ext_sel}, 16'h0001, "pointer loaded");
    rd(1, 16'h0003, "flag register");
    wr(3'h1, 1, 16'h0002);
    check({14'h0, flags}, 16'h0001, "over flag cleared");
    wr(3'h1, 1, 16'h0001);
    check({14'h0, flags}, 16'h0000, "under flag cleared");
    done_test("flag clear");
    for (int k = 2; k < 8; k++) begin
      v = {8'(k), 8'h5a ^ 8'(k)};
      if (k == 2) begin
        v[15:8] = 8'h00;
      end
      wr(3'(k), (k == 2) ? 1 : 2, v);
      check(ext_reg[k], v, "outside write");
      rd((k == 2) ? 1 : 2, v, "outside readback");
    end
    done_test("select codes");
    n = writes;
    wr(3'h0, 2, 16'hffff);
    check(16'(writes - n), 16'h0000, "no outside write");
    rd(2, 16'h0ff0, "result kept");
    n = starts;
    @(posedge mclk);
    #1;
    i_host.read_reg(DEV_ADDR_DEF ^ 7'h01, 2, w, ok);
    check({15'h0, ok}, 16'h0000, "foreign address refused");
    @(posedge mclk);
    cfg.auto_mode <= 1'b1;
    rd(2, 16'h0ff0, "result in auto mode");
    check(16'(starts - n), 16'h0000, "no start outside normal mode");
    done_test("refusals");
    convert(8'h00);
    wr(3'h5, 0, 16'h0000);
    @(posedge mclk);
    rstn <= 1'b0;
    cfg.auto_mode <= 1'b0;
    repeat (2) @(posedge mclk);
    check({10'h0, sda_out, ext_sel, flags}, 16'h0000, "state after second reset");
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    rd(2, 16'h0000, "result after second reset");
    done_test("second reset");
    results();
  end
endmodule
